/* File: dv/rwm_address_map_tb.sv */
// self-checking bench for the register window address map decoder
// assumes the decoder answers exactly one cycle after each request
`timescale 1ns/1ps
module rwm_address_map_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] windowSelectValue = 8'h00;
  logic externalAccessSelect = 1'b0;
  rwm_pkg::rwm_req_t req = '0;
  rwm_pkg::rwm_dec_t dec;
  logic extBus;
  logic sfrSel;
  logic [7:0] ramRdata;
  int n_fail = 0;
  int cmp_count = 0;
  logic [15:0] farAddr [5] = '{16'h0400, 16'h1ffd, 16'ha000, 16'hffff, 16'h03ff};
  logic [7:0] oddSel [6] = '{8'h00, 8'h0f, 8'h18, 8'h30, 8'h60, 8'h80};

  always #4 clk = ~clk;

  rwm_address_map uut (.clk(clk), .rst_b(rst_b), .windowSelectValue(windowSelectValue),
    .externalAccessSelect(externalAccessSelect), .req(req), .dec_reg(dec), .extBus_reg(extBus),
    .sfrSel_reg(sfrSel), .ramRdata(ramRdata));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // entered just after an edge; valid stays up so back-to-back calls never double-drive
  task automatic acc(input logic f, input logic w, input logic [15:0] a, input logic [7:0] d,
                     input logic [15:0] pa, input logic ew, input logic ex);
    req = '{valid: 1'b1, fetch: f, write: w, addr: a, wdata: d};
    @(posedge clk);
    #1;
    chk({15'h0, dec.valid}, 16'h0001);
    chk(dec.addr, pa);
    chk({15'h0, dec.windowed}, {15'h0, ew});
    chk({15'h0, extBus}, {15'h0, ex});
  endtask

  task automatic sweep(input logic [7:0] s0, input int n, input logic [15:0] lo, input logic [15:0] sz,
                       input int step);
    for (int i = 0; i < n; i++) begin
      // odd entries set the ignored top bit
      windowSelectValue = s0 + 8'(i) + (i[0] ? 8'h80 : 8'h00);
      acc(1'b0, 1'b0, lo + 16'(i * step), 8'h00, 16'(i) * sz + 16'(i * step), 1'b1, 1'b0);
    end
  endtask

  task automatic t_windows;
    sweep(8'h10, 8, 16'h0080, 16'h0080, 15);
    sweep(8'h20, 16, 16'h00c0, 16'h0040, 3);
    sweep(8'h40, 32, 16'h00e0, 16'h0020, 1);
    acc(1'b0, 1'b0, 16'h00ff, 8'h00, 16'h03ff, 1'b1, 1'b0);
    acc(1'b0, 1'b0, 16'h00df, 8'h00, 16'h00df, 1'b0, 1'b0);
    windowSelectValue = 8'h2f;
    acc(1'b0, 1'b0, 16'h00bf, 8'h00, 16'h00bf, 1'b0, 1'b0);
  endtask

  task automatic t_ram;
    windowSelectValue = 8'h17;
    acc(1'b0, 1'b1, 16'h00ff, 8'ha5, 16'h03ff, 1'b1, 1'b0);
    windowSelectValue = 8'h50;
    acc(1'b0, 1'b1, 16'h00e0, 8'h3c, 16'h0200, 1'b1, 1'b0);
    windowSelectValue = 8'h00;
    acc(1'b0, 1'b1, 16'h0018, 8'h77, 16'h0018, 1'b0, 1'b0);
    acc(1'b0, 1'b0, 16'h03ff, 8'h00, 16'h03ff, 1'b0, 1'b0);
    chk({8'h00, ramRdata}, 16'h00a5);
    acc(1'b0, 1'b0, 16'h0200, 8'h00, 16'h0200, 1'b0, 1'b0);
    chk({8'h00, ramRdata}, 16'h003c);
    acc(1'b0, 1'b0, 16'h0018, 8'h00, 16'h0018, 1'b0, 1'b0);
    chk({8'h00, ramRdata}, 16'h0077);
    chk({15'h0, sfrSel}, 16'h0000);
  endtask

  task automatic t_map;
    acc(1'b0, 1'b0, 16'h0017, 8'h00, 16'h0017, 1'b0, 1'b0);
    chk({15'h0, sfrSel}, 16'h0001);
    chk({13'h0, dec.region}, {13'h0, rwm_pkg::RGN_SFR});
    // reserved special-function bits are written as zero
    acc(1'b0, 1'b1, 16'h0016, 8'h00, 16'h0016, 1'b0, 1'b0);
    chk({15'h0, sfrSel}, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 1'b0, farAddr[i], 8'h00, farAddr[i], 1'b0, 1'b1);
      chk({13'h0, dec.region}, {13'h0, rwm_pkg::RGN_EXT});
    end
    acc(1'b0, 1'b0, 16'h1ffe, 8'h00, 16'h1ffe, 1'b0, 1'b0);
  endtask

  task automatic t_fetch;
    windowSelectValue = 8'h14;
    acc(1'b1, 1'b0, 16'h0085, 8'h00, 16'h0085, 1'b0, 1'b1);
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, 1'b0, farAddr[4] & 16'(i * 16'h0cff), 8'h00, farAddr[4] & 16'(i * 16'h0cff), 1'b0, 1'b1);
    end
    acc(1'b1, 1'b0, 16'h0000, 8'h00, 16'h0000, 1'b0, 1'b1);
  endtask

  task automatic t_pin;
    for (int p = 1; p >= 0; p--) begin
      externalAccessSelect = p[0];
      // two-flop synchroniser needs two edges before the pin is seen
      repeat (3) @(posedge clk);
      #1;
      acc(1'b0, 1'b0, 16'h2080, 8'h00, 16'h2080, 1'b0, !p[0]);
      acc(1'b0, 1'b0, 16'h9fff, 8'h00, 16'h9fff, 1'b0, !p[0]);
      acc(1'b0, 1'b0, 16'h2000, 8'h00, 16'h2000, 1'b0, !p[0]);
      // bytes 2014h-2017h, 2019h-201fh and 205eh-207fh stay untouched; their fill belongs to the program image
      acc(1'b0, 1'b0, 16'h205d, 8'h00, 16'h205d, 1'b0, !p[0]);
    end
  endtask

  task automatic t_unlisted;
    for (int i = 0; i < 6; i++) begin
      windowSelectValue = oddSel[i];
      acc(1'b0, 1'b0, 16'h00f0, 8'h00, 16'h00f0, 1'b0, 1'b0);
    end
  endtask

  task automatic report_and_stop;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #1;
    chk(dec.addr, 16'h0000);
    chk({15'h0, extBus}, 16'h0000);
    rst_b = 1'b1;
    t_windows();
    t_ram();
    t_map();
    t_fetch();
    t_pin();
    t_unlisted();
    report_and_stop();
  end

  // about 111 cycles are expected; this span of 2500 cycles leaves wide margin
  initial begin
    #20000;
    n_fail++;
    report_and_stop();
  end
endmodule

/* File: logic/rwm_address_map.sv */
// address decoder with vertical register windowing and the on-chip register ram
// assumes the core gives one request per cycle; external-access pin is asynchronous
// Summary of operation
// [RULE1] select 10h-17h maps 128-byte block (sel-10h)*80h onto 80h-ffh
// [RULE2] select 20h-2fh maps 64-byte block (sel-20h)*40h onto c0h-ffh
// [RULE3] select 40h-5fh maps 32-byte block (sel-40h)*20h onto e0h-ffh
// [RULE4] every byte of the register ram up to 03ffh is reachable by windows
// [RULE5] 0000h-0017h decodes as special-function registers
// [RULE6] 0018h-03ffh decodes as read/write register ram
// [RULE7] instruction fetches from 0000h-03ffh go to the external bus
// [RULE8] a000h-ffffh and 0400h-1ffdh go to the external bus
// [RULE9] 2080h-9fffh choose internal or external by the access pin
// [RULE10] access pin high serves 2000h-9fffh on chip, low sends it off chip
// [RULE11] software puts 20h at 2019h beside the configuration byte
// [RULE12] software writes zero to reserved special-function bits
// [RULE13] software never touches reserved locations
// [RULE14] other reserved program locations hold ffh
// [RULE15] an unlisted select value remaps nothing
// [RULE16] remapping only touches data accesses inside the window range
`timescale 1ns/1ps
module rwm_address_map (
  input wire logic clk, // core clock, 125 MHz
  input wire logic rst_b, // asynchronous reset, active low
  input wire logic [7:0] windowSelectValue, // window select from core
  input wire logic externalAccessSelect, // access select pin, asynchronous
  input wire rwm_pkg::rwm_req_t req, // core access request
  output rwm_pkg::rwm_dec_t dec_reg, // decoded access, one cycle later
  output logic extBus_reg, // access goes to external bus
  output logic sfrSel_reg, // access selects special-function registers
  output logic [7:0] ramRdata // ram read byte, registered in the ram
);
  logic accSelMeta_reg;
  logic accSelSync_reg;
  logic [15:0] physAddr;
  logic windowHit;
  rwm_pkg::rwm_region_t region;
  logic toExt;
  logic ramEn;

  // pin crosses into the core clock before the decoder reads it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      accSelMeta_reg <= 1'b0;
      accSelSync_reg <= 1'b0;
    end else begin
      accSelMeta_reg <= externalAccessSelect;
      accSelSync_reg <= accSelMeta_reg;
    end
  end

  function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  // top select bit is ignored; fetches never remap
  always_comb begin
    logic [6:0] sel;
    sel = windowSelectValue[6:0];
    physAddr = req.addr;
    windowHit = 1'b0;
    if (!req.fetch && req.addr[15:8] == 8'h00) begin // RULE16
      if (sel >= rwm_pkg::WIN128_BASE && sel <= rwm_pkg::WIN128_TOP
          && req.addr[7:0] >= rwm_pkg::WIN128_LO) begin // RULE1
        physAddr = {6'h00, 3'(sel - rwm_pkg::WIN128_BASE), req.addr[6:0]}; // RULE4
        windowHit = 1'b1;
      end else if (sel >= rwm_pkg::WIN64_BASE && sel <= rwm_pkg::WIN64_TOP
          && req.addr[7:0] >= rwm_pkg::WIN64_LO) begin // RULE2
        physAddr = {6'h00, 4'(sel - rwm_pkg::WIN64_BASE), req.addr[5:0]}; // RULE4
        windowHit = 1'b1;
      end else if (sel >= rwm_pkg::WIN32_BASE && sel <= rwm_pkg::WIN32_TOP
          && req.addr[7:0] >= rwm_pkg::WIN32_LO) begin // RULE3
        physAddr = {6'h00, 5'(sel - rwm_pkg::WIN32_BASE), req.addr[4:0]}; // RULE4
        windowHit = 1'b1;
      end
      // any other select value leaves the address alone
    end // RULE15
  end

  always_comb begin
    region = rwm_pkg::RGN_EXT; // RULE8
    toExt = 1'b1;
    if (inRange(physAddr, rwm_pkg::SFR_LO, rwm_pkg::SFR_HI)) begin // RULE5
      region = rwm_pkg::RGN_SFR;
      toExt = req.fetch; // RULE7
    end else if (inRange(physAddr, rwm_pkg::RAM_LO, rwm_pkg::RAM_HI)) begin // RULE6
      region = rwm_pkg::RGN_RAM;
      toExt = req.fetch; // RULE7
    end else if (inRange(physAddr, rwm_pkg::PORT_LO, rwm_pkg::PORT_HI)) begin
      region = rwm_pkg::RGN_PORT;
      toExt = 1'b0;
    end else if (inRange(physAddr, rwm_pkg::VEC_LO, rwm_pkg::VEC_HI)) begin // RULE10
      region = rwm_pkg::RGN_VECT;
      toExt = !accSelSync_reg;
    end else if (inRange(physAddr, rwm_pkg::ROM_LO, rwm_pkg::ROM_HI)) begin // RULE9
      region = rwm_pkg::RGN_ROM;
      toExt = !accSelSync_reg; // RULE10
    end
  end

  // fetches to 0018h-03ffh still decode as ram, so req.fetch is masked here and ram only sees data accesses
  assign ramEn = req.valid && !req.fetch && region == rwm_pkg::RGN_RAM;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dec_reg <= '{valid: 1'b0, region: rwm_pkg::RGN_SFR, addr: rwm_pkg::RESET_ADDR, windowed: 1'b0};
    end else begin
      dec_reg <= '{valid: req.valid, region: region, addr: physAddr, windowed: windowHit};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      extBus_reg <= 1'b0;
      sfrSel_reg <= 1'b0;
    end else begin
      extBus_reg <= req.valid && toExt;
      sfrSel_reg <= req.valid && !req.fetch && region == rwm_pkg::RGN_SFR;
    end
  end

  rwm_ram u_ram (
    .clk(clk),
    .en(ramEn),
    .we(req.write),
    .addr(physAddr[9:0]),
    .wdata(req.wdata),
    .rdata(ramRdata)
  );

  property p_win128;
    @(posedge clk) disable iff (!rst_b)
    (req.valid && !req.fetch && req.addr[15:7] == 9'h001 && windowSelectValue[6:3] == 4'h2)
      |=> (dec_reg.addr == {6'h00, $past(windowSelectValue[2:0]), $past(req.addr[6:0])} && dec_reg.windowed);
  endproperty
  a_win128: assert property (p_win128) else $error("128-byte window address wrong"); // RULE1

  property p_win64;
    @(posedge clk) disable iff (!rst_b)
    (req.valid && !req.fetch && req.addr[15:6] == 10'h003 && windowSelectValue[6:4] == 3'h2)
      |=> (dec_reg.addr == {6'h00, $past(windowSelectValue[3:0]), $past(req.addr[5:0])} && dec_reg.windowed);
  endproperty
  a_win64: assert property (p_win64) else $error("64-byte window address wrong"); // RULE2

  property p_win32;
    @(posedge clk) disable iff (!rst_b)
    (req.valid && !req.fetch && req.addr[15:5] == 11'h007 && windowSelectValue[6:5] == 2'h2)
      |=> (dec_reg.addr == {6'h00, $past(windowSelectValue[4:0]), $past(req.addr[4:0])} && dec_reg.windowed);
  endproperty
  a_win32: assert property (p_win32) else $error("32-byte window address wrong"); // RULE3

  property p_nowin;
    @(posedge clk) disable iff (!rst_b)
    (req.valid && (req.fetch || req.addr[15:8] != 8'h00)) |=> (dec_reg.addr == $past(req.addr) && !dec_reg.windowed);
  endproperty
  a_nowin: assert property (p_nowin) else $error("address remapped outside window range"); // RULE16

  property p_fetchlow;
    @(posedge clk) disable iff (!rst_b)
    (req.valid && req.fetch && req.addr <= rwm_pkg::RAM_HI) |=> extBus_reg;
  endproperty
  a_fetchlow: assert property (p_fetchlow) else $error("low fetch not sent external"); // RULE7

  property p_sfr;
    @(posedge clk) disable iff (!rst_b)
    (req.valid && !req.fetch && req.addr <= rwm_pkg::SFR_HI && !windowHit) |=> (sfrSel_reg && !extBus_reg);
  endproperty
  a_sfr: assert property (p_sfr) else $error("sfr access misdecoded"); // RULE5

  property p_ext;
    @(posedge clk) disable iff (!rst_b)
    (req.valid && (req.addr >= rwm_pkg::XIO_LO || (req.addr >= rwm_pkg::EXT_LO && req.addr <= rwm_pkg::EXT_HI)))
      |=> (extBus_reg && dec_reg.region == rwm_pkg::RGN_EXT);
  endproperty
  a_ext: assert property (p_ext) else $error("external range not sent external"); // RULE8

  property p_rom;
    @(posedge clk) disable iff (!rst_b)
    (req.valid && req.addr >= rwm_pkg::VEC_LO && req.addr <= rwm_pkg::ROM_HI) |=> (extBus_reg == !$past(accSelSync_reg));
  endproperty
  a_rom: assert property (p_rom) else $error("program memory routing ignores access pin"); // RULE10

  property p_ram;
    @(posedge clk) disable iff (!rst_b)
    (req.valid && !req.fetch && req.addr >= rwm_pkg::RAM_LO && req.addr <= rwm_pkg::RAM_HI && !windowHit)
      |=> (dec_reg.region == rwm_pkg::RGN_RAM && !extBus_reg);
  endproperty
  a_ram: assert property (p_ram) else $error("register ram misdecoded"); // RULE6

  // windows land inside the 1024-byte array, so ram addressing never wraps
  property p_winrange;
    @(posedge clk) disable iff (!rst_b)
    dec_reg.windowed |-> (dec_reg.addr <= rwm_pkg::RAM_HI);
  endproperty
  a_winrange: assert property (p_winrange) else $error("windowed address beyond register ram"); // RULE4

  property p_unlisted;
    @(posedge clk) disable iff (!rst_b)
    (req.valid && windowSelectValue[6:3] != 4'h2 && windowSelectValue[6:4] != 3'h2
      && windowSelectValue[6:5] != 2'h2)
      |=> (dec_reg.addr == $past(req.addr) && !dec_reg.windowed);
  endproperty
  a_unlisted: assert property (p_unlisted) else $error("unlisted window select remapped an address"); // RULE15

  property p_romregion;
    @(posedge clk) disable iff (!rst_b)
    (req.valid && req.addr >= rwm_pkg::ROM_LO && req.addr <= rwm_pkg::ROM_HI)
      |=> (dec_reg.region == rwm_pkg::RGN_ROM && dec_reg.valid);
  endproperty
  a_romregion: assert property (p_romregion) else $error("program memory range misdecoded"); // RULE9

  property p_vectregion;
    @(posedge clk) disable iff (!rst_b)
    (req.valid && req.addr >= rwm_pkg::VEC_LO && req.addr <= rwm_pkg::VEC_HI)
      |=> (dec_reg.region == rwm_pkg::RGN_VECT && dec_reg.valid);
  endproperty
  a_vectregion: assert property (p_vectregion) else $error("vector area misdecoded"); // RULE10

  // the port pair just above the external range must not start a bus cycle
  property p_portgap;
    @(posedge clk) disable iff (!rst_b)
    (req.valid && req.addr >= rwm_pkg::PORT_LO && req.addr <= rwm_pkg::PORT_HI)
      |=> (dec_reg.region == rwm_pkg::RGN_PORT && !extBus_reg && !sfrSel_reg);
  endproperty
  a_portgap: assert property (p_portgap) else $error("port pair sent to external bus"); // RULE8
endmodule

/* File: logic/rwm_pkg.sv */
// package for the register window address map: window encodings, memory map bounds, decode types
// assumes a 16-bit byte address from the core and an 8-bit window select value
package rwm_pkg;
  localparam logic [15:0] SFR_LO = 16'h0000;
  localparam logic [15:0] SFR_HI = 16'h0017;
  localparam logic [15:0] RAM_LO = 16'h0018;
  localparam logic [15:0] RAM_HI = 16'h03ff;
  localparam logic [15:0] EXT_LO = 16'h0400;
  localparam logic [15:0] EXT_HI = 16'h1ffd;
  localparam logic [15:0] PORT_LO = 16'h1ffe;
  localparam logic [15:0] PORT_HI = 16'h1fff;
  localparam logic [15:0] VEC_LO = 16'h2000;
  localparam logic [15:0] CFG_BYTE_ADDR = 16'h2018;
  localparam logic [15:0] CFG_PAD_ADDR = 16'h2019;
  localparam logic [15:0] VEC_HI = 16'h207f;
  localparam logic [15:0] ROM_LO = 16'h2080;
  localparam logic [15:0] ROM_HI = 16'h9fff;
  localparam logic [15:0] XIO_LO = 16'ha000;
  localparam logic [6:0] WIN128_BASE = 7'h10;
  localparam logic [6:0] WIN128_TOP = 7'h17;
  localparam logic [6:0] WIN64_BASE = 7'h20;
  localparam logic [6:0] WIN64_TOP = 7'h2f;
  localparam logic [6:0] WIN32_BASE = 7'h40;
  localparam logic [6:0] WIN32_TOP = 7'h5f;
  localparam logic [7:0] WIN128_LO = 8'h80;
  localparam logic [7:0] WIN64_LO = 8'hc0;
  localparam logic [7:0] WIN32_LO = 8'he0;
  localparam int RAM_WORDS = 1024;
  localparam logic [15:0] RESET_ADDR = 16'h0000;

  typedef enum logic [2:0] {
    RGN_SFR, RGN_RAM, RGN_EXT, RGN_PORT, RGN_VECT, RGN_ROM
  } rwm_region_t;

  typedef struct packed {
    logic valid;
    logic fetch;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } rwm_req_t;

  typedef struct packed {
    logic valid;
    rwm_region_t region;
    logic [15:0] addr;
    logic windowed;
  } rwm_dec_t;
endpackage

/* File: logic/rwm_ram.sv */
// register ram of 1024 byte cells, one port, registered read data
// assumes the decoder presents one access per cycle
`timescale 1ns/1ps
module rwm_ram (
  input wire logic clk, // core clock
  input wire logic en, // access strobe
  input wire logic we, // write when high
  input wire logic [9:0] addr, // byte address
  input wire logic [7:0] wdata, // write byte
  output logic [7:0] rdata // read byte, registered
);
  logic [7:0] mem [rwm_pkg::RAM_WORDS];

  always_ff @(posedge clk) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (en && !we) begin
      rdata <= mem[addr];
    end
  end
endmodule
